// ==== src/motor_starter_supervisor.sv ====
`timescale 1ns/100ps
// How it works
// - self-test runs at power-up or re-init
// - self-test bit starts a test in operation
// - hold time picks LED, hardware or nothing
// - LED test lights all LEDs two seconds
// - hardware test blinks device LED by current
// - self-test error steady red, power cycle clears
// - monitoring raises error; active and ok reported
// - emergency start runs motor despite internal off
// - emergency start brake after release delay
// - seven conditions block emergency start
// - emergency start from commands, input, bit
// - emergency active shown while function enabled
// - factory command only manual, elements off
// - plug address 127 restores all, any mode
// - bus address reset applied on restart only
// - after restore enter auto mode, flag set
// - restored flag held until trip reset
// - input and sensor trips latch until reset
// - end-position trip cleared by counter command
// - never both directions energised together
// - lock-out 0 to 60 s before reversing
// - zero lock-out still means 150 ms
module motor_starter_supervisor
    import motor_sup_pkg::*;
#(
    parameter int TICK_CNT = TICK_CYCLES
) (
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    input wire logic i_init,
    input wire logic i_selftest_bit,
    input wire logic i_hw_test_err,
    input wire logic i_monitor_err,
    input wire logic i_current_flow,
    input wire logic i_motor_on_cmd,
    input wire logic i_brake_on_cmd,
    input wire logic i_off_cmd,
    input wire logic i_int_off,
    input wire logic [MS_W-1:0] i_brake_delay_ms,
    input wire logic i_estart_on_cmd,
    input wire logic i_estart_off_cmd,
    input wire logic i_estart_input,
    input wire logic i_estart_bit,
    input wire logic i_dev_defect,
    input wire logic i_sw_overload,
    input wire logic i_supply_missing,
    input wire logic i_block_trip,
    input wire logic i_pi_error,
    input wire logic i_factory_cmd,
    input wire logic i_manual_mode,
    input wire logic [6:0] i_plug_addr,
    input wire logic i_restart_cmd,
    input wire logic i_trip_reset,
    input wire logic i_input_trip_evt,
    input wire logic i_sensor_ovl_evt,
    input wire logic i_endpos_cw_evt,
    input wire logic i_endpos_ccw_evt,
    input wire logic i_cw_cmd,
    input wire logic i_ccw_cmd,
    input wire logic [5:0] i_lockout_s,
    output logic o_led_all,
    output logic o_dev_led_red,
    output logic o_st_active,
    output logic o_st_ok,
    output logic o_st_error,
    output logic o_estart_active,
    output logic o_motor_on,
    output logic o_brake_on,
    output logic o_factory_restore,
    output logic o_factory_bus_reset,
    output logic o_enter_auto,
    output logic o_bus_reset_apply,
    output logic o_factory_restored,
    output logic o_input_trip,
    output logic o_sensor_ovl,
    output logic o_endpos_cw,
    output logic o_endpos_ccw,
    output logic o_cw_on,
    output logic o_ccw_on,
    output logic o_lockout_active
);
    ////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [SYNC_W-1:0] sync1_q;
    logic [SYNC_W-1:0] sync2_q;
    wire logic [SYNC_W-1:0] pins = {i_plug_addr, i_current_flow,
        i_monitor_err, i_supply_missing, i_input_trip_evt,
        i_sensor_ovl_evt, i_endpos_cw_evt, i_endpos_ccw_evt,
        i_estart_input};
    wire logic [6:0] plug_s = sync2_q[14:8];
    wire logic current_s = sync2_q[7];
    wire logic monitor_s = sync2_q[6];
    wire logic supply_s = sync2_q[5];
    wire logic in_trip_s = sync2_q[4];
    wire logic sens_ovl_s = sync2_q[3];
    wire logic end_cw_s = sync2_q[2];
    wire logic end_ccw_s = sync2_q[1];
    wire logic es_input_s = sync2_q[0];

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= pins;
            sync2_q <= sync1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // millisecond tick and blink counter
    logic [31:0] pre_q;
    logic [BLINK_W-1:0] blink_q;
    wire logic tick = (pre_q == 32'(TICK_CNT - 1));

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pre_q <= '0;
            blink_q <= '0;
        end else begin
            pre_q <= tick ? '0 : pre_q + 32'h0000_0001;
            blink_q <= blink_q + BLINK_W'(tick);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // self-test sequencer
    st_state_t st_q;
    st_state_t st_d;
    logic [MS_W-1:0] st_ms_q;
    logic [MS_W-1:0] st_ms_d;
    logic test_bit_q;
    logic boot_q;
    logic err_q;
    logic ok_q;
    wire logic test_rise = i_selftest_bit & ~test_bit_q;
    wire logic test_fall = ~i_selftest_bit & test_bit_q;
    wire logic start_led = boot_q | i_init;
    wire logic step_end = (st_q == ST_LED && st_ms_q >= LED_TEST_MS)
        || (st_q == ST_HW && st_ms_q >= HW_TEST_MS);
    wire logic ms_inc = tick && st_ms_q != '1;

    always_comb begin
        st_d = st_q;
        st_ms_d = st_ms_q + MS_W'(ms_inc);
        if (start_led) begin
            st_d = ST_LED;
            st_ms_d = '0;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    if (test_rise) begin
                        st_d = ST_HOLD;
                        st_ms_d = '0;
                    end
                end
                ST_HOLD: begin
                    if (test_fall) begin
                        st_ms_d = '0;
                        if (st_ms_q < HOLD_LED_MAX_MS) begin
                            st_d = ST_LED;
                        end else if (st_ms_q <= HOLD_HW_MAX_MS) begin
                            st_d = ST_HW;
                        end else begin
                            st_d = ST_IDLE;
                        end
                    end
                end
                ST_LED, ST_HW: begin
                    if (step_end) begin
                        st_d = ST_IDLE;
                    end
                end
                default: st_d = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            st_q <= ST_IDLE;
            st_ms_q <= '0;
            test_bit_q <= 1'b0;
            boot_q <= 1'b1;
            err_q <= 1'b0;
            ok_q <= 1'b0;
        end else begin
            st_q <= st_d;
            st_ms_q <= st_ms_d;
            test_bit_q <= i_selftest_bit;
            boot_q <= 1'b0;
            // only a power cycle clears the error
            err_q <= err_q | monitor_s
                | (i_hw_test_err && st_q == ST_HW);
            if (start_led || (st_q == ST_HOLD && test_fall)) begin
                ok_q <= 1'b0;
            end else if (step_end) begin
                ok_q <= ~err_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // emergency start and run permission
    logic es_q;
    logic [MS_W-1:0] brk_ms_q;
    wire logic es_active = es_q | es_input_s | i_estart_bit;
    wire logic es_block = i_off_cmd | i_dev_defect | err_q | i_sw_overload
        | supply_s | i_block_trip | i_pi_error;
    wire logic es_ok = es_active & ~es_block;
    wire logic tripped = i_int_off | o_input_trip | o_sensor_ovl;
    wire logic run_ok = ~i_off_cmd & (~tripped | es_ok);
    wire logic brake_req = i_brake_on_cmd & run_ok;
    wire logic brake_go = brake_req
        && brk_ms_q >= i_brake_delay_ms;

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            es_q <= 1'b0;
            brk_ms_q <= '0;
        end else begin
            es_q <= i_estart_on_cmd | (es_q & ~i_estart_off_cmd);
            if (!brake_req) begin
                brk_ms_q <= '0;
            end else if (tick && brk_ms_q != '1) begin
                brk_ms_q <= brk_ms_q + 16'h0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // reversing with lock-out
    logic cw_q;
    logic ccw_q;
    logic last_ccw_q;
    logic [MS_W-1:0] lock_q;
    wire logic [5:0] lock_s = (i_lockout_s > LOCK_MAX_S) ? LOCK_MAX_S
        : i_lockout_s;
    wire logic [MS_W-1:0] lock_set_ms = (lock_s == LOCK_RST_S)
        ? LOCK_MIN_MS : MS_W'(lock_s * LOCK_STEP_MS);
    wire logic lock_busy = (lock_q != '0);
    wire logic cw_req = i_cw_cmd & run_ok & ~o_endpos_cw;
    wire logic ccw_req = i_ccw_cmd & run_ok & ~o_endpos_ccw;
    wire logic cw_d = cw_req & ~ccw_req & ~ccw_q
        & ~(lock_busy & last_ccw_q);
    wire logic ccw_d = ccw_req & ~cw_req & ~cw_q
        & ~(lock_busy & ~last_ccw_q);
    wire logic dir_off = (cw_q & ~cw_d) | (ccw_q & ~ccw_d);

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cw_q <= 1'b0;
            ccw_q <= 1'b0;
            last_ccw_q <= 1'b0;
            lock_q <= '0;
        end else begin
            cw_q <= cw_d;
            ccw_q <= ccw_d;
            if (dir_off) begin
                last_ccw_q <= ccw_q;
                lock_q <= lock_set_ms;
            end else if (tick && lock_busy) begin
                lock_q <= lock_q - 16'h0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // factory setting and trip latches
    logic plug_hit_q, bus_pend_q, motor_q, brake_q, restore_q;
    logic bus_reset_q, apply_q, restored_q, in_trip_q, sens_q;
    logic end_cw_q, end_ccw_q;
    wire logic plug_hit = (plug_s == PLUG_RESTORE_ADDR);
    wire logic plug_restore = plug_hit & ~plug_hit_q;
    wire logic cmd_restore = i_factory_cmd & i_manual_mode & ~cw_q
        & ~ccw_q & ~motor_q & ~brake_q;
    wire logic restore = cmd_restore | plug_restore;

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            plug_hit_q <= 1'b0;
            bus_pend_q <= 1'b0;
            motor_q <= 1'b0;
            brake_q <= 1'b0;
            restore_q <= 1'b0;
            bus_reset_q <= 1'b0;
            apply_q <= 1'b0;
            restored_q <= 1'b0;
            in_trip_q <= 1'b0;
            sens_q <= 1'b0;
            end_cw_q <= 1'b0;
            end_ccw_q <= 1'b0;
        end else begin
            plug_hit_q <= plug_hit;
            motor_q <= i_motor_on_cmd & run_ok;
            brake_q <= brake_go;
            restore_q <= restore;
            bus_reset_q <= plug_restore;
            bus_pend_q <= plug_restore | (bus_pend_q & ~i_restart_cmd);
            apply_q <= bus_pend_q & i_restart_cmd;
            restored_q <= restore | (restored_q & ~i_trip_reset);
            in_trip_q <= in_trip_s | (in_trip_q & ~i_trip_reset);
            sens_q <= sens_ovl_s | (sens_q & ~i_trip_reset);
            end_cw_q <= end_cw_s | (end_cw_q & ~i_ccw_cmd);
            end_ccw_q <= end_ccw_s | (end_ccw_q & ~i_cw_cmd);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs
    wire logic hw_blink = current_s ? blink_q[FLASH_BIT]
        : blink_q[FLICKER_BIT];
    assign o_dev_led_red = err_q
        | (st_q == ST_LED) | (st_q == ST_HW && hw_blink);
    assign o_led_all = (st_q == ST_LED);
    assign o_st_active = (st_q == ST_LED) | (st_q == ST_HW);
    assign o_st_ok = ok_q;
    assign o_st_error = err_q;
    assign o_estart_active = es_active;
    assign o_motor_on = motor_q;
    assign o_brake_on = brake_q;
    assign o_factory_restore = restore_q;
    assign o_factory_bus_reset = bus_reset_q;
    assign o_enter_auto = restore_q;
    assign o_bus_reset_apply = apply_q;
    assign o_factory_restored = restored_q;
    assign o_input_trip = in_trip_q;
    assign o_sensor_ovl = sens_q;
    assign o_endpos_cw = end_cw_q;
    assign o_endpos_ccw = end_ccw_q;
    assign o_cw_on = cw_q;
    assign o_ccw_on = ccw_q;
    assign o_lockout_active = lock_busy;
endmodule : motor_starter_supervisor

// ==== src/motor_sup_pkg.sv ====
package motor_sup_pkg;
    localparam int CLK_HZ = 50_000_000;
    localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
    // millisecond time base
    localparam int TICK_TIME_NS = 1_000_000;
    localparam int TICK_CYCLES = TICK_TIME_NS / CLK_PERIOD_NS;
    localparam int MS_W = 16;
    // self-test hold windows and step lengths, in ms
    localparam logic [MS_W-1:0] HOLD_LED_MAX_MS = 16'h07D0;
    localparam logic [MS_W-1:0] HOLD_HW_MAX_MS = 16'h1388;
    localparam logic [MS_W-1:0] LED_TEST_MS = 16'h07D0;
    localparam logic [MS_W-1:0] HW_TEST_MS = 16'h07D0;
    // direction lock-out
    localparam logic [MS_W-1:0] LOCK_STEP_MS = 16'h03E8;
    localparam logic [MS_W-1:0] LOCK_MIN_MS = 16'h0096;
    localparam logic [5:0] LOCK_MAX_S = 6'h3C;
    localparam logic [5:0] LOCK_RST_S = 6'h00;
    // invalid plug address that forces a full restore
    localparam logic [6:0] PLUG_RESTORE_ADDR = 7'h7F;
    // blink bits of the free ms counter
    localparam int FLASH_BIT = 9;
    localparam int FLICKER_BIT = 6;
    localparam int BLINK_W = 10;
    localparam int SYNC_W = 15;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_HOLD,
        ST_LED,
        ST_HW
    } st_state_t;
endpackage : motor_sup_pkg

// ==== tb/motor_sup_sva.sv ====
`timescale 1ns/100ps
module motor_sup_sva (
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    input wire logic i_off_cmd,
    input wire logic i_int_off,
    input wire logic i_trip_reset,
    input wire logic i_restart_cmd,
    input wire logic o_led_all,
    input wire logic o_dev_led_red,
    input wire logic o_st_active,
    input wire logic o_st_ok,
    input wire logic o_st_error,
    input wire logic o_estart_active,
    input wire logic o_motor_on,
    input wire logic o_factory_restore,
    input wire logic o_enter_auto,
    input wire logic o_bus_reset_apply,
    input wire logic o_factory_restored,
    input wire logic o_cw_on,
    input wire logic o_ccw_on
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rstn);
    sequence ccw_held_off;
        !o_ccw_on [*8];
    endsequence
    dir_excl_a: assert property (!(o_cw_on && o_ccw_on))
        else $error("both directions on");
    rev_hold_a: assert property ($fell(o_cw_on) |-> ccw_held_off)
        else $error("reverse without lock-out");
    err_sticky_a: assert property (o_st_error |=> o_st_error)
        else $error("self-test error dropped");
    led_step_a: assert property (
        o_led_all |-> o_st_active && o_dev_led_red)
        else $error("leds on outside a step");
    err_led_a: assert property (o_st_error |-> o_dev_led_red)
        else $error("device led not red on error");
    ok_clear_a: assert property ($rose(o_st_active) |-> !o_st_ok)
        else $error("ok left set at step start");
    off_wins_a: assert property (i_off_cmd |=> !o_motor_on)
        else $error("motor on despite off command");
    trip_off_a: assert property (
        i_int_off && !o_estart_active |=> !o_motor_on)
        else $error("motor on during trip");
    restore_auto_a: assert property (
        o_factory_restore |-> o_enter_auto && o_factory_restored)
        else $error("restore without auto mode");
    flag_hold_a: assert property (
        o_factory_restored && !i_trip_reset |=> o_factory_restored)
        else $error("restored flag lost");
    apply_late_a: assert property (
        o_bus_reset_apply |-> $past(i_restart_cmd))
        else $error("bus reset applied without restart");
    cover property (o_factory_restore);
    cover property ($fell(o_cw_on));
    cover property (o_st_error);
    cover property ($rose(o_led_all));
endmodule : motor_sup_sva

bind motor_starter_supervisor motor_sup_sva i_sva (.*);

// ==== tb/motor_host.sv ====
`timescale 1ns/100ps
module motor_host (
    input wire logic i_ref_clk,
    output logic o_selftest_bit,
    output logic o_estart_bit
);
    initial begin
        o_selftest_bit = 1'b0;
        o_estart_bit = 1'b0;
    end
    task automatic hold_test(input int n);
        @(negedge i_ref_clk) o_selftest_bit = 1'b1;
        repeat (n) @(negedge i_ref_clk);
        o_selftest_bit = 1'b0;
    endtask : hold_test
    task automatic set_estart(input logic v);
        @(negedge i_ref_clk) o_estart_bit = v;
    endtask : set_estart
endmodule : motor_host

// ==== tb/motor_starter_supervisor_tb_top.sv ====
`timescale 1ns/100ps
module motor_starter_supervisor_tb_top;
    import motor_sup_pkg::*;
    logic i_ref_clk = 1'b0, i_rstn, i_init, i_hw_test_err, i_monitor_err;
    logic i_current_flow, i_motor_on_cmd, i_brake_on_cmd, i_int_off;
    logic i_estart_on_cmd, i_estart_off_cmd, i_estart_input, i_factory_cmd;
    logic i_manual_mode, i_restart_cmd, i_trip_reset, i_cw_cmd, i_ccw_cmd;
    logic i_selftest_bit, i_estart_bit, o_led_all, o_dev_led_red;
    logic o_st_active, o_st_ok, o_st_error, o_estart_active, o_motor_on;
    logic o_brake_on, o_factory_restore, o_factory_bus_reset, o_enter_auto;
    logic o_bus_reset_apply, o_factory_restored, o_cw_on, o_ccw_on;
    logic o_lockout_active;
    logic [MS_W-1:0] i_brake_delay_ms;
    logic [6:0] i_plug_addr;
    logic [5:0] i_lockout_s, blk;
    logic [3:0] evt, trp;
    int error_cnt = 0, samples_checked = 0;
    motor_starter_supervisor #(.TICK_CNT(10)) i_dut (.*,
        .i_dev_defect(blk[0]), .i_sw_overload(blk[1]),
        .i_supply_missing(blk[2]), .i_block_trip(blk[3]),
        .i_pi_error(blk[4]), .i_off_cmd(blk[5]),
        .i_input_trip_evt(evt[0]), .i_sensor_ovl_evt(evt[1]),
        .i_endpos_cw_evt(evt[2]), .i_endpos_ccw_evt(evt[3]),
        .o_input_trip(trp[0]), .o_sensor_ovl(trp[1]),
        .o_endpos_cw(trp[2]), .o_endpos_ccw(trp[3]));
    motor_host i_host (.i_ref_clk(i_ref_clk),
        .o_selftest_bit(i_selftest_bit), .o_estart_bit(i_estart_bit));
    always #10 i_ref_clk = ~i_ref_clk;
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input logic e, input logic g);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected at %0t: exp %h got %h", $time, e, g);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(negedge i_ref_clk);
    endtask : cyc
    task automatic print_verdict;
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : print_verdict
    ////////////////////////////////////////////////////////////////////
    task automatic t_boot;
        int n;
        cyc(2);
        chk(1'b1, o_led_all);
        chk(1'b1, o_st_active);
        for (n = 0; n < 21000 && o_st_active !== 1'b0; n++) cyc(1);
        chk(1'b1, n > 19900 && n < 20100);
        chk(1'b1, o_st_ok);
        i_init = 1'b1;
        cyc(1);
        i_init = 1'b0;
        cyc(1);
        chk(1'b1, o_led_all);
    endtask : t_boot
    task automatic t_estart;
        int s, b;
        {i_int_off, i_motor_on_cmd, i_brake_on_cmd} = 3'b111;
        cyc(5);
        chk(1'b0, o_motor_on);
        for (s = 0; s < 3; s++) begin
            i_estart_on_cmd = (s == 0);
            i_estart_input = (s == 1);
            if (s == 2) i_host.set_estart(1'b1);
            cyc(1);
            i_estart_on_cmd = 1'b0;
            cyc(4);
            chk(1'b1, o_estart_active);
            chk(1'b1, o_motor_on);
            chk(1'b0, o_brake_on);
            cyc(50);
            chk(1'b1, o_brake_on);
            for (b = 0; b < 6; b++) begin
                blk[b] = 1'b1;
                cyc(5);
                chk(1'b0, o_motor_on);
                chk(1'b1, o_estart_active);
                blk[b] = 1'b0;
                cyc(1);
            end
            i_estart_off_cmd = (s == 0);
            i_estart_input = 1'b0;
            if (s == 2) i_host.set_estart(1'b0);
            cyc(1);
            i_estart_off_cmd = 1'b0;
            cyc(4);
            chk(1'b0, o_estart_active);
            chk(1'b0, o_motor_on);
        end
        {i_int_off, i_motor_on_cmd, i_brake_on_cmd} = 3'b000;
        cyc(2);
    endtask : t_estart
    task automatic t_fac;
        int n, seen;
        i_factory_cmd = 1'b1;
        cyc(1);
        i_factory_cmd = 1'b0;
        chk(1'b0, o_factory_restore);
        i_manual_mode = 1'b1;
        i_factory_cmd = 1'b1;
        cyc(1);
        i_factory_cmd = 1'b0;
        chk(1'b1, o_factory_restore);
        chk(1'b0, o_factory_bus_reset);
        chk(1'b1, o_enter_auto);
        cyc(50);
        chk(1'b1, o_factory_restored);
        i_manual_mode = 1'b0;
        i_plug_addr = 7'h7F;
        seen = 0;
        for (n = 0; n < 10; n++) begin
            cyc(1);
            seen += (o_factory_bus_reset === 1'b1);
        end
        chk(1'b1, seen == 1);
        chk(1'b0, o_bus_reset_apply);
        i_restart_cmd = 1'b1;
        cyc(1);
        i_restart_cmd = 1'b0;
        chk(1'b1, o_bus_reset_apply);
        i_trip_reset = 1'b1;
        cyc(1);
        i_trip_reset = 1'b0;
        cyc(1);
        chk(1'b0, o_factory_restored);
    endtask : t_fac
    task automatic t_trip;
        int i;
        for (i = 0; i < 4; i++) begin
            evt[i] = 1'b1;
            cyc(1);
            evt[i] = 1'b0;
            cyc(20);
            chk(1'b1, trp[i]);
            i_trip_reset = (i < 2);
            i_ccw_cmd = (i == 2);
            i_cw_cmd = (i == 3);
            cyc(1);
            {i_trip_reset, i_cw_cmd, i_ccw_cmd} = 3'b000;
            cyc(3);
            chk(1'b0, trp[i]);
        end
    endtask : t_trip
    task automatic t_rev;
        cyc(1600);
        i_cw_cmd = 1'b1;
        cyc(3);
        chk(1'b1, o_cw_on);
        {i_cw_cmd, i_ccw_cmd} = 2'b01;
        cyc(1400);
        chk(1'b0, o_ccw_on);
        chk(1'b1, o_lockout_active);
        cyc(200);
        chk(1'b1, o_ccw_on);
        i_lockout_s = 6'h01;
        {i_cw_cmd, i_ccw_cmd} = 2'b10;
        cyc(9000);
        chk(1'b0, o_cw_on);
        cyc(1200);
        chk(1'b1, o_cw_on);
        {i_cw_cmd, i_ccw_cmd} = 2'b11;
        cyc(3);
        chk(1'b0, o_cw_on || o_ccw_on);
        {i_cw_cmd, i_ccw_cmd} = 2'b00;
    endtask : t_rev
    task automatic t_hw;
        int n, a, b;
        logic p;
        for (n = 0; n < 21000 && o_st_active !== 1'b0; n++) cyc(1);
        i_current_flow = 1'b1;
        i_host.hold_test(25000);
        cyc(3);
        chk(1'b1, o_st_active);
        chk(1'b0, o_led_all);
        {a, b, p} = {32'h0000_0000, 32'h0000_0000, o_dev_led_red};
        for (n = 0; n < 12000; n++) begin
            cyc(1);
            if (n == 6000) i_current_flow = 1'b0;
            if (n < 6000) a += (o_dev_led_red !== p);
            else b += (o_dev_led_red !== p);
            p = o_dev_led_red;
        end
        chk(1'b1, a >= 1 && a <= 2);
        chk(1'b1, b >= 8);
        i_hw_test_err = 1'b1;
        cyc(3);
        i_hw_test_err = 1'b0;
        chk(1'b1, o_st_error);
        for (n = 0; n < 21000 && o_st_active !== 1'b0; n++) cyc(1);
        cyc(700);
        chk(1'b1, o_dev_led_red);
        chk(1'b0, o_st_ok);
    endtask : t_hw
    task automatic t_pwr;
        i_rstn = 1'b0;
        cyc(2);
        i_rstn = 1'b1;
        cyc(2);
        chk(1'b0, o_st_error);
        chk(1'b1, o_led_all);
        i_monitor_err = 1'b1;
        cyc(4);
        i_monitor_err = 1'b0;
        cyc(1);
        chk(1'b1, o_st_error);
        {i_trip_reset, i_init} = 2'b11;
        cyc(1);
        {i_trip_reset, i_init} = 2'b00;
        cyc(1);
        chk(1'b1, o_st_error);
    endtask : t_pwr
    ////////////////////////////////////////////////////////////////////
    initial begin
        {i_init, i_hw_test_err, i_monitor_err, i_current_flow} = 4'h0;
        {i_motor_on_cmd, i_brake_on_cmd, i_int_off, i_estart_on_cmd} = 4'h0;
        {i_estart_off_cmd, i_estart_input, i_factory_cmd} = 3'b000;
        {i_manual_mode, i_restart_cmd, i_trip_reset} = 3'b000;
        {i_cw_cmd, i_ccw_cmd, i_plug_addr, i_lockout_s} = 15'h0000;
        {blk, evt} = 10'h000;
        i_brake_delay_ms = 16'h0003;
        i_rstn = 1'b0;
        cyc(8);
        i_rstn = 1'b1;
        t_boot;
        t_estart;
        t_fac;
        t_trip;
        t_rev;
        t_hw;
        t_pwr;
        print_verdict;
    end
    initial begin
        repeat (100000) @(posedge i_ref_clk);
        error_cnt++;
        print_verdict;
    end
endmodule : motor_starter_supervisor_tb_top
